/* File: cmp_pkg.sv */
// constants shared by the comparator control block
package cmp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX   = 8'h9b;
    localparam logic [7:0] MODE_IDX   = 8'h9d;
    localparam logic [7:0] RSTCFG_IDX = 8'ha0;

    // control register fields
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_OUT_BIT   = 6;
    localparam int CTRL_RISE_BIT  = 5;
    localparam int CTRL_FALL_BIT  = 4;
    localparam int CTRL_HYP_LSB   = 2;
    localparam int CTRL_HYN_LSB   = 0;

    // mode register fields
    localparam int MODE_RIE_BIT   = 5;
    localparam int MODE_FIE_BIT   = 4;
    localparam int MODE_MD_LSB    = 0;

    // reset-source register fields
    localparam int RSTCFG_EN_BIT  = 0;

    // reset values
    localparam logic       CTRL_EN_RST   = 1'b0;
    localparam logic       FLAG_RST      = 1'b0;
    localparam logic [1:0] HYST_RST      = 2'h0;
    localparam logic       IRQ_EN_RST    = 1'b0;
    localparam logic [1:0] RESP_MODE_RST = 2'h2;
    localparam logic       RST_SRC_RST   = 1'b0;

    // hysteresis encodings: off, 5 mV, 10 mV, 20 mV
    localparam logic [1:0] HYST_OFF  = 2'h0;
    localparam logic [1:0] HYST_5MV  = 2'h1;
    localparam logic [1:0] HYST_10MV = 2'h2;
    localparam logic [1:0] HYST_20MV = 2'h3;

    // response modes: fastest to slowest
    localparam logic [1:0] RESP_FAST = 2'h0;
    localparam logic [1:0] RESP_SLOW = 2'h3;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmp_pkg

/* File: cmp_edge_if.sv */
// synchronised comparator level and edge pulses between modules
`timescale 1ns/1ps
`default_nettype none
interface cmp_edge_if;
    logic syncLevel;
    logic risePulse;
    logic fallPulse;
    modport source (output syncLevel, output risePulse, output fallPulse);
    modport sink   (input  syncLevel, input  risePulse, input  fallPulse);
endinterface : cmp_edge_if
`default_nettype wire

/* File: cmp_edge_sync.sv */
// two-flop synchroniser and edge detector for the raw comparator result
`timescale 1ns/1ps
`default_nettype none
module cmp_edge_sync
    import cmp_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // raw analog result
    input  wire logic cmpRaw,
    // synchronised result
    cmp_edge_if.source edges
);

    logic metaR_r;
    logic syncR_r;
    logic prevR_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            metaR_r <= 1'b0;
            syncR_r <= 1'b0;
            prevR_r <= 1'b0;
        end else begin
            metaR_r <= cmpRaw;
            syncR_r <= metaR_r;
            prevR_r <= syncR_r;
        end
    end

    assign edges.syncLevel = syncR_r;
    assign edges.risePulse = syncR_r & ~prevR_r;
    assign edges.fallPulse = ~syncR_r & prevR_r;

    property p_rise_two_stage;
        @(posedge mclk) disable iff (!rst_b)
        !syncR_r ##1 syncR_r |-> edges.risePulse;
    endproperty
    a_rise_two_stage: assert property (p_rise_two_stage)
        else $error("rise pulse missing after sync stage");

endmodule : cmp_edge_sync
`default_nettype wire

/* File: voltage_comparator.sv */
// control and status logic around the analog voltage comparator
//
// Behaviour
// - latched and raw comparator outputs to pins
// - raw output needs no clock
// - comparator result can request device reset
// - disabled: pin outputs low, power off
// - response mode passed to analog core
// - low four control bits set hysteresis
// - hysteresis: off, 5, 10, 20 mV
// - interrupts on rising and falling edges
// - edges set rise or fall flag
// - flags stay set until software clears
// - enable bits unmask edge interrupts
// - output state readable at any time
// - enable bit turns comparator on, off
// - control register bit layout, reset zero
// - hysteresis field encodings and positions
// - mode register layout, mode resets to 10
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module voltage_comparator
    import cmp_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    // axi4-lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // analog core
    input  wire logic              cmpRaw,
    output logic                   cmpPowerOn,
    output logic [1:0]             cmpPosHyst,
    output logic [1:0]             cmpNegHyst,
    output logic [1:0]             cmpResponseMode,
    // crossbar outputs
    output logic                   cmpSyncOut,
    output logic                   cmpAsyncOut,
    // interrupt and reset requests
    output logic                   cmpRiseIrq,
    output logic                   cmpFallIrq,
    output logic                   cmpResetReq
);

    function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
        regAddr = ADDR_W'({idx, 2'b00});
    endfunction : regAddr

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        isMapped = (addr == regAddr(CTRL_IDX)) ||
                   (addr == regAddr(MODE_IDX)) ||
                   (addr == regAddr(RSTCFG_IDX));
    endfunction : isMapped

    // register state
    logic       cmpEnable_r;
    logic       cmpRiseFlag_r;
    logic       cmpFallFlag_r;
    logic [1:0] cmpPosHyst_r;
    logic [1:0] cmpNegHyst_r;
    logic       cmpRiseIrqEn_r;
    logic       cmpFallIrqEn_r;
    logic [1:0] cmpRespMode_r;
    logic       cmpResetEn_r;
    logic       cmpSyncOut_r;

    // bus state
    logic              awHeld_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic              wHeld_r;
    logic [31:0]       wData_r;
    logic              wLane0_r;
    logic              bValid_r;
    logic [1:0]        bResp_r;
    logic              rValid_r;
    logic [31:0]       rData_r;
    logic [1:0]        rResp_r;

    cmp_edge_if edgeBus ();

    cmp_edge_sync u_sync (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .cmpRaw (cmpRaw),
        .edges  (edgeBus)
    );

    // ---------------- comparator view ----------------
    logic cmpState;
    logic riseSeen;
    logic fallSeen;

    assign cmpState = cmpEnable_r & edgeBus.syncLevel;
    assign riseSeen = cmpEnable_r & edgeBus.risePulse;
    assign fallSeen = cmpEnable_r & edgeBus.fallPulse;

    // ---------------- write path ----------------
    logic doWrite;
    logic wrCtrl;
    logic wrMode;
    logic wrRst;
    logic [7:0] wByte;

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready  = !wHeld_r && !bValid_r;
    assign doWrite = awHeld_r && wHeld_r && !bValid_r;
    assign wByte   = wData_r[7:0];
    assign wrCtrl  = doWrite && wLane0_r && (awAddr_r == regAddr(CTRL_IDX));
    assign wrMode  = doWrite && wLane0_r && (awAddr_r == regAddr(MODE_IDX));
    assign wrRst   = doWrite && wLane0_r &&
                     (awAddr_r == regAddr(RSTCFG_IDX));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld_r  <= 1'b0;
            wData_r  <= '0;
            wLane0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r  <= 1'b1;
            wData_r  <= s_axi_wdata;
            wLane0_r <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bValid_r <= 1'b0;
            bResp_r  <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_r <= 1'b1;
            bResp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp  = bResp_r;

    // ---------------- control register ----------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmpEnable_r  <= CTRL_EN_RST;
            cmpPosHyst_r <= HYST_RST;
            cmpNegHyst_r <= HYST_RST;
        end else if (wrCtrl) begin
            cmpEnable_r  <= wByte[CTRL_EN_BIT];
            cmpPosHyst_r <= wByte[CTRL_HYP_LSB +: 2];
            cmpNegHyst_r <= wByte[CTRL_HYN_LSB +: 2];
        end
    end

    // software write first, hardware set on top of it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmpRiseFlag_r <= FLAG_RST;
            cmpFallFlag_r <= FLAG_RST;
        end else begin
            cmpRiseFlag_r <= (wrCtrl ? wByte[CTRL_RISE_BIT] : cmpRiseFlag_r)
                             | riseSeen;
            cmpFallFlag_r <= (wrCtrl ? wByte[CTRL_FALL_BIT] : cmpFallFlag_r)
                             | fallSeen;
        end
    end

    // ---------------- mode and reset-source registers ----------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmpRiseIrqEn_r <= IRQ_EN_RST;
            cmpFallIrqEn_r <= IRQ_EN_RST;
            cmpRespMode_r  <= RESP_MODE_RST;
        end else if (wrMode) begin
            cmpRiseIrqEn_r <= wByte[MODE_RIE_BIT];
            cmpFallIrqEn_r <= wByte[MODE_FIE_BIT];
            cmpRespMode_r  <= wByte[MODE_MD_LSB +: 2];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmpResetEn_r <= RST_SRC_RST;
        end else if (wrRst) begin
            cmpResetEn_r <= wByte[RSTCFG_EN_BIT];
        end
    end

    // ---------------- read path ----------------
    logic [7:0] rdByte;

    always_comb begin
        rdByte = 8'h00;
        if (s_axi_araddr == regAddr(CTRL_IDX)) begin
            rdByte[CTRL_EN_BIT]         = cmpEnable_r;
            rdByte[CTRL_OUT_BIT]        = cmpState;
            rdByte[CTRL_RISE_BIT]       = cmpRiseFlag_r;
            rdByte[CTRL_FALL_BIT]       = cmpFallFlag_r;
            rdByte[CTRL_HYP_LSB +: 2]   = cmpPosHyst_r;
            rdByte[CTRL_HYN_LSB +: 2]   = cmpNegHyst_r;
        end else if (s_axi_araddr == regAddr(MODE_IDX)) begin
            rdByte[MODE_RIE_BIT]        = cmpRiseIrqEn_r;
            rdByte[MODE_FIE_BIT]        = cmpFallIrqEn_r;
            rdByte[MODE_MD_LSB +: 2]    = cmpRespMode_r;
        end else if (s_axi_araddr == regAddr(RSTCFG_IDX)) begin
            rdByte[RSTCFG_EN_BIT]       = cmpResetEn_r;
        end
    end

    assign s_axi_arready = !rValid_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rValid_r <= 1'b0;
            rData_r  <= '0;
            rResp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_r <= 1'b1;
            rData_r  <= {24'h000000, rdByte};
            rResp_r  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata  = rData_r;
    assign s_axi_rresp  = rResp_r;

    // ---------------- outputs ----------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmpSyncOut_r <= 1'b0;
        end else begin
            cmpSyncOut_r <= cmpState;
        end
    end

    assign cmpSyncOut  = cmpSyncOut_r;
    // unclocked path stays live while the system clock is stopped
    assign cmpAsyncOut = cmpEnable_r & cmpRaw;
    assign cmpPowerOn  = cmpEnable_r;
    assign cmpPosHyst  = cmpPosHyst_r;
    assign cmpNegHyst  = cmpNegHyst_r;
    assign cmpResponseMode = cmpRespMode_r;
    assign cmpRiseIrq  = cmpRiseFlag_r & cmpRiseIrqEn_r;
    assign cmpFallIrq  = cmpFallFlag_r & cmpFallIrqEn_r;
    // reset request while the positive input sits below the negative
    assign cmpResetReq = cmpEnable_r & cmpResetEn_r &
                         ~edgeBus.syncLevel;

    // ---------------- assertions ----------------
    sequence s_rise_event;
        riseSeen;
    endsequence

    sequence s_fall_event;
        fallSeen;
    endsequence

    property p_rise_sets;
        @(posedge mclk) disable iff (!rst_b)
        s_rise_event |=> cmpRiseFlag_r;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rise flag not set after rising edge");

    property p_fall_sets;
        @(posedge mclk) disable iff (!rst_b)
        s_fall_event |=> cmpFallFlag_r;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("fall flag not set after falling edge");

    property p_flag_sticky;
        @(posedge mclk) disable iff (!rst_b)
        (cmpRiseFlag_r && !wrCtrl) |=> cmpRiseFlag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("rise flag cleared without a write");

    property p_set_wins;
        @(posedge mclk) disable iff (!rst_b)
        (wrCtrl && !wByte[CTRL_FALL_BIT] && fallSeen) |=> cmpFallFlag_r;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("fall event lost against a clearing write");

    property p_off_low;
        @(posedge mclk) disable iff (!rst_b)
        !cmpEnable_r |-> (!cmpAsyncOut && !cmpPowerOn && !cmpState);
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("disabled comparator drives output or power");

    property p_sync_lag;
        @(posedge mclk) disable iff (!rst_b)
        (cmpEnable_r && edgeBus.syncLevel) ##1 cmpEnable_r |-> cmpSyncOut;
    endproperty
    a_sync_lag: assert property (p_sync_lag)
        else $error("latched output does not follow synced result");

    property p_irq_mask;
        @(posedge mclk) disable iff (!rst_b)
        cmpRiseIrq |-> (cmpRiseFlag_r && cmpRiseIrqEn_r);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("rise interrupt raised while masked");

    property p_enable_write;
        @(posedge mclk) disable iff (!rst_b)
        wrCtrl |=> (cmpEnable_r == $past(wByte[CTRL_EN_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit does not take written value");

    property p_mode_write;
        @(posedge mclk) disable iff (!rst_b)
        wrMode |=> (cmpResponseMode == $past(wByte[MODE_MD_LSB +: 2]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("response mode not passed to analog core");

    property p_write_resp;
        @(posedge mclk) disable iff (!rst_b)
        doWrite |=> s_axi_bvalid [*1] ##0 !s_axi_awready;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing one cycle after write");

endmodule : voltage_comparator
`default_nettype wire

/* File: cmp_analog_model.sv */
// behavioural model of the analog comparator core
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model
    import cmp_pkg::*;
(
    // control from the block
    input  wire logic       powerOn,
    input  wire logic [1:0] responseMode,
    // input voltages: plus above minus
    input  wire logic       inPlusHigh,
    // raw result
    output logic            cmpRaw
);
    // unpowered core floats high; slower mode answers later, always off
    // the clock grid so the block never sees a change at its edge
    initial cmpRaw = 1'b1;
    always @(powerOn or inPlusHigh) begin
        if (powerOn === 1'b1) begin
            cmpRaw <= #(3 + 2 * int'(responseMode)) inPlusHigh;
        end else begin
            cmpRaw <= #3 1'b1;
        end
    end
endmodule : cmp_analog_model
`default_nettype wire

/* File: tb_voltage_comparator.sv */
// self-checking testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_voltage_comparator
    import cmp_pkg::*;
;
    localparam logic [11:0] CTRL_A = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] MODE_A = {2'h0, MODE_IDX, 2'h0};
    localparam logic [11:0] RST_A  = {2'h0, RSTCFG_IDX, 2'h0};
    localparam logic [11:0] BAD_A  = 12'h100;
    logic        mclk, rst_b, clkRun, inPlusHigh;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, posHyst, negHyst, respMode;
    logic        cmpRaw, powerOn, syncOut, asyncOut, riseIrq, fallIrq;
    logic        resetReq;
    logic [3:0]  wstrb;
    logic [33:0] expRead[$];
    logic [1:0]  expResp[$];
    int          errors = 0;
    int          checksDone = 0;

    voltage_comparator dut_u (
        .mclk(mclk), .rst_b(rst_b),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .cmpRaw(cmpRaw), .cmpPowerOn(powerOn), .cmpPosHyst(posHyst),
        .cmpNegHyst(negHyst), .cmpResponseMode(respMode),
        .cmpSyncOut(syncOut), .cmpAsyncOut(asyncOut),
        .cmpRiseIrq(riseIrq), .cmpFallIrq(fallIrq), .cmpResetReq(resetReq)
    );

    cmp_analog_model core_u (
        .powerOn(powerOn), .responseMode(respMode),
        .inPlusHigh(inPlusHigh), .cmpRaw(cmpRaw)
    );

    always #10 if (clkRun) mclk = ~mclk;

    task automatic fail(input string msg);
        $display("wrong value at %0t: %s", $time, msg);
        errors++;
    endtask : fail

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic check_read(input logic [33:0] got, input logic [33:0] exp);
        checksDone++;
        if (got !== exp) fail("read response or data");
    endtask : check_read

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checksDone++;
        if (got !== exp) fail("write response");
    endtask : check_resp

    task automatic check_pin(input logic [1:0] got, input logic [1:0] exp,
                             input string what);
        checksDone++;
        if (got !== exp) fail(what);
    endtask : check_pin

    // takes the oldest expectation as each bus answer is accepted
    always @(posedge mclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (expRead.size() == 0) fail("unexpected read answer");
            else check_read({rresp, rdata}, expRead.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (expResp.size() == 0) fail("unexpected write answer");
            else check_resp(bresp, expResp.pop_front());
        end
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        int n = 0;
        expResp.push_back(r);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        // bready stays high between transfers
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("write never answered");
            wrap_up();
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        int n = 0;
        expRead.push_back({r, 24'h0, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        // rready stays high between transfers
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("read never answered");
            wrap_up();
        end
    endtask : rd

    // waits for the raw level, then for the synchroniser and flag stages
    task automatic settle(input logic v);
        int n = 0;
        while (cmpRaw !== v && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 100) begin
            fail("raw level never settled");
            wrap_up();
        end
        repeat (4) @(posedge mclk);
    endtask : settle

    initial begin
        #400us;
        fail("run timed out");
        wrap_up();
    end

    initial begin
        logic [1:0] h;
        logic [7:0] v;
        mclk = 1'b0;
        rst_b = 1'b0;
        clkRun = 1'b1;
        inPlusHigh = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        v = 8'($urandom(32'h99d414d8));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(CTRL_A, 8'h00, RESP_OKAY);
        rd(MODE_A, {6'h0, RESP_MODE_RST}, RESP_OKAY);
        rd(RST_A, 8'h00, RESP_OKAY);
        rd(BAD_A, 8'h00, RESP_SLVERR);
        wr(BAD_A, 8'hff, RESP_SLVERR);
        check_pin(respMode, RESP_MODE_RST, "mode pin at reset");
        check_pin({1'b0, powerOn}, 2'h0, "power at reset");
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            h = 2'(i);
            wr(CTRL_A, {4'h0, h, ~h}, RESP_OKAY);
            wr(MODE_A, {6'h0, h}, RESP_OKAY);
            check_pin(posHyst, h, "positive hysteresis");
            check_pin(negHyst, ~h, "negative hysteresis");
            check_pin(respMode, h, "response mode pin");
            rd(CTRL_A, {4'h0, h, ~h}, RESP_OKAY);
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom());
            wr(MODE_A, v, RESP_OKAY);
            rd(MODE_A, v & 8'h33, RESP_OKAY);
            wr(CTRL_A, v & 8'h7f, RESP_OKAY);
            rd(CTRL_A, v & 8'h3f, RESP_OKAY);
        end
        // a write without byte lane 0 leaves the register alone
        wstrb <= 4'he;
        wr(CTRL_A, 8'hff, RESP_OKAY);
        wstrb <= 4'hf;
        rd(CTRL_A, v & 8'h3f, RESP_OKAY);
        wr(MODE_A, 8'h00, RESP_OKAY);
        $display("test field encodings done");

        wr(RST_A, 8'h01, RESP_OKAY);
        wr(CTRL_A, 8'h80, RESP_OKAY);
        settle(1'b0);
        wr(CTRL_A, 8'h80, RESP_OKAY);
        check_pin({1'b0, resetReq}, 2'h1, "reset request low");
        inPlusHigh <= 1'b1;
        settle(1'b1);
        rd(CTRL_A, 8'he0, RESP_OKAY);
        check_pin({1'b0, syncOut}, 2'h1, "latched output");
        check_pin({1'b0, asyncOut}, 2'h1, "raw output");
        check_pin({1'b0, resetReq}, 2'h0, "reset request high");
        check_pin({1'b0, riseIrq}, 2'h0, "masked rise");
        wr(MODE_A, 8'h30, RESP_OKAY);
        check_pin({1'b0, riseIrq}, 2'h1, "rise interrupt");
        check_pin({1'b0, fallIrq}, 2'h0, "no fall interrupt");
        inPlusHigh <= 1'b0;
        settle(1'b0);
        rd(CTRL_A, 8'hb0, RESP_OKAY);
        check_pin({1'b0, fallIrq}, 2'h1, "fall interrupt");
        wr(CTRL_A, 8'h90, RESP_OKAY);
        rd(CTRL_A, 8'h90, RESP_OKAY);
        check_pin({1'b0, riseIrq}, 2'h0, "rise cleared");
        $display("test edge flags done");

        // raw path must follow with the clock stopped
        clkRun = 1'b0;
        inPlusHigh = 1'b1;
        #60;
        check_pin({1'b0, asyncOut}, 2'h1, "raw without clock");
        inPlusHigh = 1'b0;
        // restart between two ticks of the clock generator
        #65;
        check_pin({1'b0, asyncOut}, 2'h0, "raw without clock");
        clkRun = 1'b1;
        @(posedge mclk);
        $display("test stopped clock done");

        // clearing write lands in the cycle of a falling edge
        inPlusHigh <= 1'b1;
        settle(1'b1);
        inPlusHigh <= 1'b0;
        @(posedge mclk);
        wr(CTRL_A, 8'h80, RESP_OKAY);
        rd(CTRL_A, 8'h90, RESP_OKAY);
        $display("test set against clear done");

        wr(CTRL_A, 8'h00, RESP_OKAY);
        inPlusHigh <= 1'b1;
        repeat (8) @(posedge mclk);
        check_pin({1'b0, powerOn}, 2'h0, "power off");
        check_pin({syncOut, asyncOut}, 2'h0, "outputs low");
        rd(CTRL_A, 8'h00, RESP_OKAY);
        $display("test disable done");
        wrap_up();
    end
endmodule : tb_voltage_comparator
`default_nettype wire
